// File: gpt_pkg.sv
`default_nettype none
package gpt_pkg;
  // register byte offsets on the AXI4-Lite slave
  localparam logic [3:0] OFF_CONTROL = 4'h0;
  localparam logic [3:0] OFF_PERIOD = 4'h4;
  localparam logic [3:0] OFF_COUNT = 4'h8;
  localparam logic [3:0] OFF_STATUS = 4'hC;
  localparam logic [3:0] OFF_MASK = 4'h0;
  localparam logic [4:0] OFF_IRQ_CFG = 5'h10;
  // control register field positions
  localparam int RUN_BIT = 15;
  localparam int IDLE_BIT = 13;
  localparam int GATE_BIT = 6;
  localparam int PS_LO = 4;
  localparam int SYNC_BIT = 2;
  localparam int SRC_BIT = 1;
  localparam logic [15:0] CONTROL_WMASK = 16'hA076;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
  // status bits: 0 period match, 1 gate falling edge
  localparam int EV_MATCH = 0;
  localparam int EV_GATE = 1;
  localparam int NUM_EV = 2;
  // prescale terminal counts (divide minus one)
  localparam logic [7:0] PS_DIV1 = 8'h00;
  localparam logic [7:0] PS_DIV8 = 8'h07;
  localparam logic [7:0] PS_DIV64 = 8'h3F;
  localparam logic [7:0] PS_DIV256 = 8'hFF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic run;
    logic idle_halt;
    logic gate_accum_en;
    logic [1:0] prescale_sel;
    logic ext_clk_sync_sel;
    logic clk_src_sel;
  } gpt_ctl_t;
endpackage : gpt_pkg
`default_nettype wire

// File: gpt_timer.sv
// Contract
// R01: three modes: internal timer, synchronised counter, unsynchronised external counter.
// R02: usable as rtc time base or free-running interval timer/counter.
// R03: control bit 15 starts counting when one, stops when zero.
// R04: control bit 13 halts counting while cpu idle; clear keeps counting.
// R05: bit 6 enables gated accumulation with internal clock only.
// R06: bits 5-4 prescale 1:1, 1:8, 1:64, 1:256.
// R07: bit 2 synchronises external clock when set; ignored on internal clock.
// R08: bit 1 selects external clock rising edges, else internal clock.
// R09: changing prescale while running resets the prescale counter.
// R10: count compared with period register; match ends the interval.
// R11: interrupt on period match or gate falling edge in gated mode.
// R12: interrupt delivered only when enabled; three-bit priority level output.
// R13: control bits 14, 12-7, 3, 0 read as zero.
// R14: after a match the count returns to zero on next count tick.
`default_nettype none
module gpt_timer (
  // clock, reset, enable
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic CLK_EN,
  // system status and pins
  input wire logic CPU_IDLE,
  input wire logic EXT_CLK_PIN,
  input wire logic GATE_PIN,
  // axi4-lite write address and data
  input wire logic [4:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  // axi4-lite write response
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // axi4-lite read
  input wire logic [4:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // interrupt
  output logic IRQ,
  output logic [2:0] IRQ_PRIORITY
);

  ////////////////////////////////////////////////////////////////////////////
  // registers
  // clock enable low freezes every register below, bus handshakes included
  logic [15:0] control_reg;
  logic [15:0] period_value_reg;
  logic [15:0] count_reg;
  logic [1:0] status_reg;
  logic [1:0] mask_reg;
  logic irq_enable_reg;
  logic [2:0] irq_priority_reg;
  gpt_pkg::gpt_ctl_t ctl;

  // control fields decoded once; unimplemented bits never reach the logic
  assign ctl.run = control_reg[gpt_pkg::RUN_BIT];
  assign ctl.idle_halt = control_reg[gpt_pkg::IDLE_BIT];
  assign ctl.gate_accum_en = control_reg[gpt_pkg::GATE_BIT];
  assign ctl.prescale_sel = control_reg[gpt_pkg::PS_LO +: 2];
  assign ctl.ext_clk_sync_sel = control_reg[gpt_pkg::SYNC_BIT];
  assign ctl.clk_src_sel = control_reg[gpt_pkg::SRC_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave: address and data latched separately, answer once both held
  logic aw_held_reg;
  logic w_held_reg;
  logic [4:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic wr_fire;
  logic rd_fire;

  // a new write waits until the previous response has been taken
  assign wr_fire = aw_held_reg && w_held_reg && !S_AXI_BVALID;
  assign rd_fire = S_AXI_ARVALID && S_AXI_ARREADY;

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 5'h00;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= gpt_pkg::RESP_OKAY;
    end else if (CLK_EN) begin
      S_AXI_AWREADY <= !aw_held_reg && !S_AXI_AWREADY;
      S_AXI_WREADY <= !w_held_reg && !S_AXI_WREADY;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= S_AXI_AWADDR;
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held_reg <= 1'b1;
        wdata_reg <= S_AXI_WDATA;
        wstrb_reg <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end
      if (wr_fire) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= (awaddr_reg > gpt_pkg::OFF_IRQ_CFG || awaddr_reg[1:0] != 2'h0)
                       ? gpt_pkg::RESP_SLVERR : gpt_pkg::RESP_OKAY;
      end
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
      end
    end
  end

  // control, period and interrupt configuration writes
  // refused addresses still answer, but change no register
  logic wr_ok;
  assign wr_ok = wr_fire && awaddr_reg[1:0] == 2'h0;

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      control_reg <= gpt_pkg::CONTROL_RESET;
      period_value_reg <= gpt_pkg::PERIOD_RESET;
      mask_reg <= 2'h0;
      irq_enable_reg <= 1'b0;
      irq_priority_reg <= 3'h0;
    end else if (CLK_EN && wr_ok) begin
      case (awaddr_reg)
        {1'b0, gpt_pkg::OFF_CONTROL}: begin
          // unstrobed byte lanes keep their old contents
          if (wstrb_reg[0]) begin
            control_reg[7:0] <= wdata_reg[7:0] & gpt_pkg::CONTROL_WMASK[7:0]; // R13
          end
          if (wstrb_reg[1]) begin
            control_reg[15:8] <= wdata_reg[15:8] & gpt_pkg::CONTROL_WMASK[15:8]; // R13
          end
        end
        {1'b0, gpt_pkg::OFF_PERIOD}: begin
          if (wstrb_reg[0]) begin
            period_value_reg[7:0] <= wdata_reg[7:0]; // R10
          end
          if (wstrb_reg[1]) begin
            period_value_reg[15:8] <= wdata_reg[15:8]; // R10
          end
        end
        gpt_pkg::OFF_IRQ_CFG: begin
          mask_reg <= wdata_reg[1:0];
          irq_enable_reg <= wdata_reg[8]; // R12
          irq_priority_reg <= wdata_reg[18:16]; // R12
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel: one cycle from address accept to rvalid
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    case (S_AXI_ARADDR)
      {1'b0, gpt_pkg::OFF_CONTROL}: rd_mux = {16'h0000, control_reg}; // R13
      {1'b0, gpt_pkg::OFF_PERIOD}: rd_mux = {16'h0000, period_value_reg};
      {1'b0, gpt_pkg::OFF_COUNT}: rd_mux = {16'h0000, count_reg};
      {1'b0, gpt_pkg::OFF_STATUS}: rd_mux = {30'h0, status_reg};
      gpt_pkg::OFF_IRQ_CFG: rd_mux = {13'h0, irq_priority_reg, 7'h00, irq_enable_reg,
                                      6'h00, mask_reg};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h00000000;
      S_AXI_RRESP <= gpt_pkg::RESP_OKAY;
    end else if (CLK_EN) begin
      // read data is captured at the address handshake and held until rready
      S_AXI_ARREADY <= !S_AXI_RVALID && !S_AXI_ARREADY;
      if (rd_fire) begin
        S_AXI_ARREADY <= 1'b0;
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA <= rd_mux;
        S_AXI_RRESP <= (S_AXI_ARADDR > gpt_pkg::OFF_IRQ_CFG || S_AXI_ARADDR[1:0] != 2'h0)
                       ? gpt_pkg::RESP_SLVERR : gpt_pkg::RESP_OKAY;
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // count clock source
  logic ext_s1_reg;
  logic ext_s2_reg;
  logic ext_prev_reg;
  logic raw_prev_reg;
  logic gate_prev_reg;
  logic ext_edge;
  logic gate_fall;
  logic src_tick;
  logic internal_tick_reg;

  // each pin level must last a full clock, or its edge is missed
  // two-stage synchroniser; first stage feeds only the second
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
      ext_prev_reg <= 1'b0;
      raw_prev_reg <= 1'b0;
      gate_prev_reg <= 1'b0;
      internal_tick_reg <= 1'b0;
    end else if (CLK_EN) begin
      ext_s1_reg <= EXT_CLK_PIN;
      ext_s2_reg <= ext_s1_reg;
      ext_prev_reg <= ext_s2_reg;
      raw_prev_reg <= EXT_CLK_PIN;
      gate_prev_reg <= GATE_PIN;
      internal_tick_reg <= !internal_tick_reg; // R08
    end
  end

  // unsynchronised path samples the pin directly, two stages less latency
  assign ext_edge = ctl.ext_clk_sync_sel ? (ext_s2_reg && !ext_prev_reg)
                                         : (EXT_CLK_PIN && !raw_prev_reg); // R07 R01
  assign gate_fall = gate_prev_reg && !GATE_PIN;

  // gated mode counts internal ticks only while the gate is high
  always_comb begin
    if (ctl.clk_src_sel) begin
      src_tick = ext_edge; // R08 R05
    end else if (ctl.gate_accum_en) begin
      src_tick = internal_tick_reg && GATE_PIN; // R05
    end else begin
      src_tick = internal_tick_reg; // R01
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // prescaler and counter
  logic [7:0] ps_cnt_reg;
  logic [7:0] ps_term;
  logic [1:0] ps_sel_prev_reg;
  logic active;
  logic count_tick;
  logic match;

  always_comb begin
    case (ctl.prescale_sel)
      2'h0: ps_term = gpt_pkg::PS_DIV1; // R06
      2'h1: ps_term = gpt_pkg::PS_DIV8;
      2'h2: ps_term = gpt_pkg::PS_DIV64;
      2'h3: ps_term = gpt_pkg::PS_DIV256;
      default: ps_term = gpt_pkg::PS_DIV1;
    endcase
  end

  assign active = ctl.run && !(ctl.idle_halt && CPU_IDLE); // R03 R04
  // the count advances only on the last source tick of each prescale cycle
  assign count_tick = active && src_tick && (ps_cnt_reg == ps_term);
  assign match = (count_reg == period_value_reg); // R10

  // a divide change while running restarts the prescaler, so one interval runs long
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ps_cnt_reg <= 8'h00;
      ps_sel_prev_reg <= 2'h0;
    end else if (CLK_EN) begin
      ps_sel_prev_reg <= ctl.prescale_sel;
      if (ctl.run && ps_sel_prev_reg != ctl.prescale_sel) begin
        ps_cnt_reg <= 8'h00; // R09
      end else if (active && src_tick) begin
        ps_cnt_reg <= (ps_cnt_reg == ps_term) ? 8'h00 : ps_cnt_reg + 8'h01; // R06
      end
    end
  end

  // free-running interval counter, doubles as rtc time base
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      count_reg <= 16'h0000;
    end else if (CLK_EN && count_tick) begin
      count_reg <= match ? 16'h0000 : count_reg + 16'h0001; // R14 R02
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // events, sticky status and interrupt
  logic match_prev_reg;
  logic [1:0] ev;
  logic [1:0] w1c;

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      match_prev_reg <= 1'b0;
    end else if (CLK_EN) begin
      match_prev_reg <= match && ctl.run;
    end
  end

  // match fires once when the count reaches the period, not while it dwells
  assign ev[gpt_pkg::EV_MATCH] = match && ctl.run && !match_prev_reg; // R11
  // the gate event obeys run and idle halt like the counter does
  assign ev[gpt_pkg::EV_GATE] = gate_fall && ctl.gate_accum_en && !ctl.clk_src_sel
                                && active; // R11 R05
  assign w1c = (wr_ok && awaddr_reg == {1'b0, gpt_pkg::OFF_STATUS}) ? wdata_reg[1:0] : 2'h0;

  genvar gi;
  generate
    for (gi = 0; gi < gpt_pkg::NUM_EV; gi++) begin : g_status
      always_ff @(posedge SYS_CLK) begin
        if (RST) begin
          status_reg[gi] <= 1'b0;
        end else if (CLK_EN) begin
          // set wins over a same-cycle clear
          status_reg[gi] <= ev[gi] | (status_reg[gi] & !w1c[gi]);
        end
      end
    end
  endgenerate

  // one cycle behind the status bits; priority is reported, not arbitrated
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      IRQ <= 1'b0;
      IRQ_PRIORITY <= 3'h0;
    end else if (CLK_EN) begin
      IRQ <= irq_enable_reg && |(status_reg & mask_reg); // R12
      IRQ_PRIORITY <= irq_priority_reg; // R12
    end
  end

endmodule : gpt_timer
`default_nettype wire

// File: gpt_properties.sv
`default_nettype none
module gpt_properties (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST,
  // read channel
  input wire logic [4:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0] S_AXI_RRESP,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // write channel and interrupt
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic IRQ
);
  logic [4:0] rd_addr_reg;
  logic rd_bad;
  always_ff @(posedge SYS_CLK) begin
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rd_addr_reg <= S_AXI_ARADDR;
    end
  end
  assign rd_bad = (rd_addr_reg > 5'h10) || (rd_addr_reg[1:0] != 2'h0);
  ////////////////////////////////
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  a_ar_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read answer late");
  a_r_hold: assert property (
    S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped");
  a_r_cause: assert property ($rose(S_AXI_RVALID) |-> $past(S_AXI_ARVALID && S_AXI_ARREADY))
    else $error("read answer without request");
  a_ctl_unused: assert property (
    S_AXI_RVALID && rd_addr_reg == 5'h00 |-> (S_AXI_RDATA & 32'hFFFF5F89) == 32'h0)
    else $error("unused control bits set");
  a_bad_addr: assert property (
    S_AXI_RVALID && rd_bad |-> S_AXI_RRESP == 2'h2 && S_AXI_RDATA == 32'h0)
    else $error("bad address not refused");
  a_good_addr: assert property (S_AXI_RVALID && !rd_bad |-> S_AXI_RRESP == 2'h0
    && S_AXI_RDATA[31:19] == 13'h0 && (rd_addr_reg == 5'h10 || S_AXI_RDATA[18:16] == 3'h0))
    else $error("good read wrong");
  a_b_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY |-> ##[1:4] S_AXI_BVALID)
    else $error("write answer late");
  a_b_single: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
    else $error("write answer repeated");
  a_irq_reset: assert property ($fell(RST) |-> !IRQ)
    else $error("interrupt out of reset");
  cover property ($rose(IRQ));
  cover property (S_AXI_RVALID && S_AXI_RRESP == 2'h2);
  cover property (S_AXI_BVALID && S_AXI_BRESP == 2'h2);
endmodule : gpt_properties
bind gpt_timer gpt_properties chk_i (.*);
`default_nettype wire

// File: gpt_pins.sv
`default_nettype none
module gpt_pins (
  // clock and pins
  input wire logic clk,
  output logic ext_clk,
  output logic gate
);
  timeunit 1ns;
  timeprecision 1ps;
  // the pin clock stands low between bursts
  initial begin
    ext_clk = 1'h0;
    gate = 1'h0;
  end
  task automatic pulses(input int n);
    repeat (n) begin
      repeat (2) @(posedge clk);
      ext_clk <= 1'h1;
      repeat (2) @(posedge clk);
      ext_clk <= 1'h0;
    end
  endtask : pulses
  task automatic gate_win(input int n);
    @(posedge clk);
    gate <= 1'h1;
    repeat (n) @(posedge clk);
    gate <= 1'h0;
  endtask : gate_win
endmodule : gpt_pins
`default_nettype wire

// File: gpt_timer_tb.sv
`default_nettype none
module gpt_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0, rst = 1'h1, idle = 1'h0, rready = 1'h0;
  logic en = 1'h1, bready = 1'h0;
  logic [3:0] strb = 4'hF;
  logic awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0;
  logic [4:0] awaddr = 5'h0, araddr = 5'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic awready, wready, arready, bvalid, rvalid, irq, xclk, gate;
  logic [1:0] bresp, rresp;
  logic [2:0] prio;
  int fail_count = 0, compares = 0, gap;
  int div[4] = '{1, 8, 64, 256};
  always #2.5 clk = ~clk;
  gpt_timer uut (.SYS_CLK(clk), .RST(rst), .CLK_EN(en), .CPU_IDLE(idle),
    .EXT_CLK_PIN(xclk), .GATE_PIN(gate), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(strb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .IRQ(irq), .IRQ_PRIORITY(prio));
  gpt_pins pins (.clk(clk), .ext_clk(xclk), .gate(gate));
  ////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    while (!bvalid) @(posedge clk);
    bready <= 1'h0;
    chk(32'(bresp), 32'(er));
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'h0;
    // ready held back one cycle so the slave must hold its answer
    @(posedge clk);
    rready <= 1'h1;
    do @(posedge clk); while (!rvalid);
    rready <= 1'h0;
    chk(rdata, e);
    chk(32'(rresp), 32'(er));
  endtask : rd
  task automatic gap_meas(input int f, output int g);
    longint t0;
    // drop any stale match event so the first rise timed is a fresh match
    wr(5'hC, 32'h1, 2'h0);
    while (irq) @(posedge clk);
    while (!irq) @(posedge clk);
    t0 = $time;
    wr(5'hC, 32'h1, 2'h0);
    if (f > 0) begin
      en <= 1'h0;
      repeat (f) @(posedge clk);
      en <= 1'h1;
    end
    while (irq) @(posedge clk);
    while (!irq) @(posedge clk);
    g = int'(($time - t0) / 5);
  endtask : gap_meas
  task automatic do_reset;
    @(posedge clk);
    rst <= 1'h1;
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
  endtask : do_reset
  task automatic final_report;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report
  ////////////////////////////////
  initial begin
    do_reset;
    rd(5'h00, 32'h0, 2'h0);
    rd(5'h04, 32'hFFFF, 2'h0);
    rd(5'h10, 32'h0, 2'h0);
    rd(5'h14, 32'h0, 2'h2);
    rd(5'h02, 32'h0, 2'h2);
    strb <= 4'h1;
    wr(5'h04, 32'h1234, 2'h0);
    strb <= 4'hF;
    rd(5'h04, 32'hFF34, 2'h0);
    wr(5'h14, 32'h1, 2'h2);
    wr(5'h00, 32'hFFFF, 2'h0);
    rd(5'h00, 32'hA076, 2'h0);
    wr(5'h04, 32'h7, 2'h0);
    wr(5'h10, 32'h50103, 2'h0);
    @(posedge clk);
    chk(32'(prio), 32'h5);
    idle <= 1'h1;
    for (int i = 0; i < 4; i++) begin
      wr(5'h00, 32'h8000 | (i << 4), 2'h0);
      gap_meas(0, gap);
      chk(gap, 16 * div[i]);
    end
    wr(5'h00, 32'hA000, 2'h0);
    wr(5'h0C, 32'h3, 2'h0);
    repeat (100) @(posedge clk);
    rd(5'h0C, 32'h0, 2'h0);
    idle <= 1'h0;
    // frozen cycles stretch the interval one for one
    gap_meas(100, gap);
    chk(gap, 116);
    wr(5'h00, 32'h0, 2'h0);
    wr(5'h0C, 32'h3, 2'h0);
    repeat (100) @(posedge clk);
    rd(5'h0C, 32'h0, 2'h0);
    for (int s = 0; s < 2; s++) begin
      do_reset;
      wr(5'h04, 32'h7, 2'h0);
      wr(5'h00, 32'h8042 | (s << 2), 2'h0);
      pins.pulses(6);
      pins.gate_win(4);
      rd(5'h0C, 32'h0, 2'h0);
      pins.pulses(1);
      repeat (4) @(posedge clk);
      rd(5'h0C, 32'h1, 2'h0);
    end
    do_reset;
    wr(5'h00, 32'h8040, 2'h0);
    pins.gate_win(20);
    repeat (4) @(posedge clk);
    rd(5'h0C, 32'h2, 2'h0);
    chk(32'(irq), 32'h0);
    wr(5'h10, 32'h2, 2'h0);
    chk(32'(irq), 32'h0);
    wr(5'h10, 32'h102, 2'h0);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h1);
    wr(5'h0C, 32'h2, 2'h0);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0);
    final_report;
  end
  initial begin
    #400000;
    fail_count++;
    final_report;
  end
endmodule : gpt_timer_tb
`default_nettype wire
